// ### src/timer8_pkg.sv
package timer8_pkg;

    // APB request as issued by the master.
    typedef struct packed {
        logic [9:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
        logic psel;
        logic penable;
    } apb_req_type;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_CTRL_A = 8'h30;
    localparam logic [7:0] IDX_CTRL_B = 8'h33;
    localparam logic [7:0] IDX_COUNT = 8'h32;
    localparam logic [7:0] IDX_CMP_A = 8'h36;
    localparam logic [7:0] IDX_STATUS = 8'h38;
    localparam logic [7:0] IDX_CMP_B = 8'h3c;

    // Field positions in timer_control_a.
    localparam int ACT_A_LSB = 6;
    localparam int ACT_B_LSB = 4;
    localparam int WGM_LOW_LSB = 0;
    // Field positions in timer_control_b.
    localparam int FORCE_A_BIT = 7;
    localparam int FORCE_B_BIT = 6;
    localparam int WGM_HIGH_BIT = 3;
    localparam int CLK_SEL_LSB = 0;
    // Field positions in the status register.
    localparam int STATUS_OVF_BIT = 0;
    localparam int STATUS_MATCH_LSB = 1;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_STEP = 8'h01;

    // Waveform modes.
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_PC_MAX = 3'h1;
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] WGM_PC_CMPA = 3'h5;
    localparam logic [2:0] WGM_FAST_CMPA = 3'h7;

    // Clock sources.
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // Prescaler terminal masks for divide by 8, 64, 256 and 1024.
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV64_MASK = 10'h03f;
    localparam logic [9:0] DIV256_MASK = 10'h0ff;
    localparam logic [9:0] DIV1024_MASK = 10'h3ff;
    localparam logic [9:0] PRESCALE_STEP = 10'h001;

    typedef enum logic {COUNT_UP, COUNT_DOWN} count_dir_type;

    function automatic logic [9:0] reg_addr(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction

endpackage

// ### src/timer_tick_select.sv
`timescale 1ns/1ps
module timer_tick_select
    import timer8_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] clk_src_select,
    input wire logic ext_count_pin,
    output logic tick
);

    logic ext_meta_q;
    logic ext_sync_q;
    logic ext_prev_q;
    logic [9:0] prescale_q;
    logic rise;
    logic fall;

    // The pin is asynchronous; the first stage is never looked at, and edges are found from the second and third stages.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_meta_q <= ext_count_pin;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    // Free running, so a new source selection does not restart the divider.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_q <= '0;
        end else begin
            prescale_q <= prescale_q + PRESCALE_STEP;
        end
    end

    // The pin is sampled regardless of its port direction.
    assign rise = ext_sync_q & ~ext_prev_q;
    assign fall = ~ext_sync_q & ext_prev_q;

    always_comb begin
        unique case (clk_src_select)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (prescale_q & DIV8_MASK) == DIV8_MASK;
            CS_DIV64: tick = (prescale_q & DIV64_MASK) == DIV64_MASK;
            CS_DIV256: tick = (prescale_q & DIV256_MASK) == DIV256_MASK;
            CS_DIV1024: tick = (prescale_q & DIV1024_MASK) == DIV1024_MASK;
            CS_EXT_FALL: tick = fall;
            CS_EXT_RISE: tick = rise;
        endcase
    end

endmodule

// ### src/timer8_waveform_control.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
module timer8_waveform_control
    import timer8_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire apb_req_type apb_req,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic ext_count_pin,
    input wire logic dir_out_a,
    input wire logic dir_out_b,
    output logic cmp_out_a_pin,
    output logic cmp_out_a_oe,
    output logic cmp_out_a_override,
    output logic cmp_out_b_pin,
    output logic cmp_out_b_oe,
    output logic cmp_out_b_override,
    output logic overflow_flag
);

    localparam int CH_A = 0;
    localparam int NUM_CH = 2;

    logic [1:0] out_action_q [NUM_CH];
    logic [2:0] wave_gen_select_q;
    logic [2:0] clk_src_select_q;
    logic [7:0] count_value_q;
    logic [7:0] count_value_d;
    count_dir_type dir_q;
    count_dir_type dir_d;
    logic [7:0] cmp_buf_q [NUM_CH];
    logic [7:0] cmp_live_q [NUM_CH];
    logic [NUM_CH-1:0] out_q;
    logic [NUM_CH-1:0] match_flag_q;
    logic overflow_q;
    logic block_q;
    logic [31:0] prdata_q;

    logic tick;
    logic access;
    logic wr;
    logic hit_ctrl_a;
    logic hit_ctrl_b;
    logic hit_count;
    logic hit_cmp_a;
    logic hit_cmp_b;
    logic hit_status;
    logic mapped;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic is_fast;
    logic is_pc;
    logic is_pwm;
    logic [7:0] top;
    logic count_write;
    logic ovf_event;
    logic update_point;
    logic [NUM_CH-1:0] hit_cmp;
    logic [NUM_CH-1:0] force_cmp;
    logic [NUM_CH-1:0] match;
    logic [NUM_CH-1:0] dir_out;

    timer_tick_select u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .clk_src_select(clk_src_select_q),
        .ext_count_pin(ext_count_pin),
        .tick(tick)
    );

    // Bus decode. The slave never inserts wait states.
    assign access = apb_req.psel & apb_req.penable;
    assign wr = access & apb_req.pwrite;
    assign wbyte = apb_req.pwdata[7:0];
    assign hit_ctrl_a = apb_req.paddr == reg_addr(IDX_CTRL_A);
    assign hit_ctrl_b = apb_req.paddr == reg_addr(IDX_CTRL_B);
    assign hit_count = apb_req.paddr == reg_addr(IDX_COUNT);
    assign hit_cmp_a = apb_req.paddr == reg_addr(IDX_CMP_A);
    assign hit_cmp_b = apb_req.paddr == reg_addr(IDX_CMP_B);
    assign hit_status = apb_req.paddr == reg_addr(IDX_STATUS);
    assign hit_cmp = {hit_cmp_b, hit_cmp_a};
    assign mapped = hit_ctrl_a | hit_ctrl_b | hit_count | hit_cmp_a | hit_cmp_b | hit_status;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_q;

    // Mode decode; reserved modes 4 and 6 count like normal mode.
    assign is_fast = (wave_gen_select_q == WGM_FAST_MAX)
                     || (wave_gen_select_q == WGM_FAST_CMPA);
    assign is_pc = (wave_gen_select_q == WGM_PC_MAX)
                   || (wave_gen_select_q == WGM_PC_CMPA);
    assign is_pwm = is_fast | is_pc;
    assign top = ((wave_gen_select_q == WGM_CTC) || (wave_gen_select_q == WGM_PC_CMPA)
                  || (wave_gen_select_q == WGM_FAST_CMPA)) ? cmp_live_q[CH_A] : COUNT_MAX;

    // A counter write takes priority over a tick in the same cycle.
    assign count_write = wr & hit_count;
    // Forcing uses the mode in force before the write; PWM ignores it.
    assign force_cmp[0] = wr & hit_ctrl_b & wbyte[FORCE_A_BIT] & ~is_pwm;
    assign force_cmp[1] = wr & hit_ctrl_b & wbyte[FORCE_B_BIT] & ~is_pwm;
    assign update_point = tick & (count_value_q == top) & (is_fast | (dir_q == COUNT_UP));
    assign dir_out = {dir_out_b, dir_out_a};

    always_comb begin
        unique case (1'b1)
            is_pc: ovf_event = tick & (count_value_q == COUNT_BOTTOM);
            wave_gen_select_q == WGM_FAST_CMPA: ovf_event = tick & (count_value_q == top);
            default: ovf_event = tick & (count_value_q == COUNT_MAX);
        endcase
    end

    always_comb begin
        count_value_d = count_value_q + COUNT_STEP;
        dir_d = COUNT_UP;
        if (is_pc) begin
            unique case (dir_q)
                COUNT_UP: begin
                    if (count_value_q >= top) begin
                        dir_d = COUNT_DOWN;
                        count_value_d = count_value_q - COUNT_STEP;
                    end
                end
                COUNT_DOWN: begin
                    if (count_value_q == COUNT_BOTTOM) begin
                        dir_d = COUNT_UP;
                    end else begin
                        dir_d = COUNT_DOWN;
                        count_value_d = count_value_q - COUNT_STEP;
                    end
                end
            endcase
        end else if ((is_fast || wave_gen_select_q == WGM_CTC) && count_value_q == top) begin
            count_value_d = COUNT_BOTTOM;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_q <= REG_RESET;
            dir_q <= COUNT_UP;
        end else if (count_write) begin
            count_value_q <= wbyte;
        end else if (tick) begin
            count_value_q <= count_value_d;
            dir_q <= dir_d;
        end
    end

    // Software writes to the counter mask the very next compare.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_q <= 1'b0;
        end else if (count_write) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_action_q[0] <= '0;
            out_action_q[1] <= '0;
            wave_gen_select_q <= '0;
            clk_src_select_q <= CS_STOP;
        end else if (wr && hit_ctrl_a) begin
            out_action_q[0] <= wbyte[ACT_A_LSB +: 2];
            out_action_q[1] <= wbyte[ACT_B_LSB +: 2];
            wave_gen_select_q[1:0] <= wbyte[WGM_LOW_LSB +: 2];
        end else if (wr && hit_ctrl_b) begin
            wave_gen_select_q[2] <= wbyte[WGM_HIGH_BIT];
            clk_src_select_q <= wbyte[CLK_SEL_LSB +: 3];
        end
    end

    // A flag raised in the same cycle as its clear stays set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_q <= 1'b0;
        end else if (ovf_event) begin
            overflow_q <= 1'b1;
        end else if (wr && hit_status && wbyte[STATUS_OVF_BIT]) begin
            overflow_q <= 1'b0;
        end
    end
    assign overflow_flag = overflow_q;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic [1:0] act;
        logic ignore_top;
        logic chan_toggle_ok;

        assign act = out_action_q[i];
        assign match[i] = tick & ~block_q & (count_value_q == cmp_live_q[i]);
        assign ignore_top = (cmp_live_q[i] == top) & act[1];
        // Only channel A may toggle in PWM modes, and only with a compare-A TOP.
        assign chan_toggle_ok = (i == CH_A) & wave_gen_select_q[2] & (act == 2'b01);

        // Double buffered in PWM modes so a period never sees a torn value.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cmp_buf_q[i] <= REG_RESET;
                cmp_live_q[i] <= REG_RESET;
            end else begin
                if (wr && hit_cmp[i]) begin
                    cmp_buf_q[i] <= wbyte;
                end
                if (!is_pwm) begin
                    cmp_live_q[i] <= (wr && hit_cmp[i]) ? wbyte : cmp_buf_q[i];
                end else if (update_point) begin
                    cmp_live_q[i] <= cmp_buf_q[i];
                end
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                out_q[i] <= 1'b0;
            end else if (is_fast) begin
                if (tick && count_value_q == top && act[1]) begin
                    out_q[i] <= ~act[0];
                end else if (match[i] && act[1] && !ignore_top) begin
                    out_q[i] <= act[0];
                end else if (match[i] && chan_toggle_ok) begin
                    out_q[i] <= ~out_q[i];
                end
            end else if (is_pc) begin
                if (tick && count_value_q == top && ignore_top) begin
                    out_q[i] <= ~act[0];
                end else if (match[i] && act[1] && !ignore_top) begin
                    out_q[i] <= (dir_q == COUNT_UP) ? act[0] : ~act[0];
                end else if (match[i] && chan_toggle_ok) begin
                    out_q[i] <= ~out_q[i];
                end
            end else if (force_cmp[i] || match[i]) begin
                unique case (act)
                    2'b00: out_q[i] <= out_q[i];
                    2'b01: out_q[i] <= ~out_q[i];
                    2'b10: out_q[i] <= 1'b0;
                    2'b11: out_q[i] <= 1'b1;
                endcase
            end
        end

        // Forced compares never reach this flag.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                match_flag_q[i] <= 1'b0;
            end else if (match[i]) begin
                match_flag_q[i] <= 1'b1;
            end else if (wr && hit_status && wbyte[STATUS_MATCH_LSB + i]) begin
                match_flag_q[i] <= 1'b0;
            end
        end
    end

    assign cmp_out_a_pin = out_q[0];
    assign cmp_out_b_pin = out_q[1];
    assign cmp_out_a_override = out_action_q[0] != 2'b00;
    assign cmp_out_b_override = out_action_q[1] != 2'b00;
    assign cmp_out_a_oe = cmp_out_a_override & dir_out[0];
    assign cmp_out_b_oe = cmp_out_b_override & dir_out[1];

    always_comb begin
        rbyte = 8'h00;
        unique case (1'b1)
            hit_ctrl_a: rbyte = {out_action_q[0], out_action_q[1], 2'b00,
                                 wave_gen_select_q[1:0]};
            hit_ctrl_b: rbyte = {4'h0, wave_gen_select_q[2], clk_src_select_q};
            hit_count: rbyte = count_value_q;
            hit_cmp_a: rbyte = cmp_buf_q[0];
            hit_cmp_b: rbyte = cmp_buf_q[1];
            hit_status: rbyte = {5'h00, match_flag_q, overflow_q};
            default: rbyte = 8'h00;
        endcase
    end

    // Read data are captured in the setup cycle, so a read shows the
    // state one cycle before the access edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
            prdata_q <= {24'h000000, rbyte};
        end
    end

endmodule

// ### sim/timer8_wave_asserts.sv
`timescale 1ns/1ps
module timer8_wave_asserts
    import timer8_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire apb_req_type apb_req,
    input wire logic [31:0] prdata,
    input wire logic dir_out_a,
    input wire logic dir_out_b,
    input wire logic cmp_out_a_oe,
    input wire logic cmp_out_a_override,
    input wire logic cmp_out_b_pin,
    input wire logic cmp_out_b_oe,
    input wire logic cmp_out_b_override,
    input wire logic overflow_flag
);
    logic [7:0] ctrl_a_q;
    logic [2:0] cs_q;
    logic wr_on;
    logic rd_on;
    logic frc_b;
    logic ovf_clr;
    assign wr_on = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_on = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign ovf_clr = wr_on && apb_req.paddr == {IDX_STATUS, 2'b00} && apb_req.pwdata[0];
    // Only forces with the timer stopped are judged, so no tick can mask the effect.
    assign frc_b = wr_on && apb_req.paddr == {IDX_CTRL_B, 2'b00} && apb_req.pwdata[FORCE_B_BIT]
        && cs_q == CS_STOP && apb_req.pwdata[2:0] == CS_STOP;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_q <= REG_RESET;
        end else if (wr_on && apb_req.paddr == {IDX_CTRL_A, 2'b00}) begin
            ctrl_a_q <= apb_req.pwdata[7:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_q <= CS_STOP;
        end else if (wr_on && apb_req.paddr == {IDX_CTRL_B, 2'b00}) begin
            cs_q <= apb_req.pwdata[2:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bit 0 of the mode is set in exactly the four PWM modes.
    chk_force_level: assert property (
        frc_b && !ctrl_a_q[0] && ctrl_a_q[5] |=> cmp_out_b_pin == $past(ctrl_a_q[4]))
        else $error("forced level wrong");
    chk_force_toggle: assert property (
        frc_b && !ctrl_a_q[0] && ctrl_a_q[5:4] == 2'b01 |=> cmp_out_b_pin != $past(cmp_out_b_pin))
        else $error("forced toggle missing");
    chk_force_pwm: assert property (
        frc_b && ctrl_a_q[0] |=> $stable(cmp_out_b_pin))
        else $error("force acted in pwm mode");
    chk_force_noflag: assert property (
        frc_b && !overflow_flag |=> !overflow_flag)
        else $error("force raised a flag");
    chk_ovf_sticky: assert property (
        $fell(overflow_flag) |-> $past(ovf_clr))
        else $error("overflow flag dropped alone");
    chk_zero_ctrl_a: assert property (
        rd_on && apb_req.paddr == {IDX_CTRL_A, 2'b00}
        |=> prdata[31:8] == 24'h0 && prdata[3:2] == 2'b00)
        else $error("unused control a bits set");
    chk_zero_ctrl_b: assert property (
        rd_on && apb_req.paddr == {IDX_CTRL_B, 2'b00} |=> prdata[7:4] == 4'h0)
        else $error("control b reads nonzero bits");
    chk_override_b: assert property (
        cmp_out_b_override == (ctrl_a_q[5:4] != 2'b00))
        else $error("override b mismatch");
    chk_oe_b: assert property (
        cmp_out_b_oe == (cmp_out_b_override && dir_out_b))
        else $error("enable b mismatch");
    chk_oe_a: assert property (
        cmp_out_a_oe == (cmp_out_a_override && dir_out_a))
        else $error("enable a mismatch");
    cov_force: cover property (frc_b && !ctrl_a_q[0]);
    cov_ovf: cover property ($rose(overflow_flag));
    cov_pwm_rise: cover property (ctrl_a_q[0] && $rose(cmp_out_b_pin));
endmodule

bind timer8_waveform_control timer8_wave_asserts chk_u (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .prdata(prdata), .dir_out_a(dir_out_a), .dir_out_b(dir_out_b),
    .cmp_out_a_oe(cmp_out_a_oe), .cmp_out_a_override(cmp_out_a_override),
    .cmp_out_b_pin(cmp_out_b_pin), .cmp_out_b_oe(cmp_out_b_oe),
    .cmp_out_b_override(cmp_out_b_override), .overflow_flag(overflow_flag));

// ### sim/timer8_waveform_control_bench.sv
`timescale 1ns/1ps
module timer8_waveform_control_bench
    import timer8_pkg::*;
;
    logic pclk;
    logic presetn;
    apb_req_type apb_req;
    logic ext_count_pin;
    logic dir_out_a;
    logic dir_out_b;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic oa;
    logic oa_ov;
    logic ob;
    logic ob_oe;
    logic ob_ov;
    logic ovf;
    int err_total = 0;
    int compares = 0;
    int seed = 34;
    logic [31:0] r;
    logic [64:0] note;
    logic [64:0] exp_q[$];
    int divs[6] = '{1, 1, 8, 64, 256, 1024};
    // Fields: ctrl_a, ctrl_b, compare b, expected high cycles in two periods, or in eight for the compare-A TOP row.
    logic [39:0] rows[7] = '{40'h2301400082, 40'h330140017e, 40'h2301ff0200,
        40'h2309100088, 40'h2101400100, 40'h31014002fc, 40'h2101ff03fc};

    timer8_waveform_control dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
        .dir_out_a(dir_out_a), .dir_out_b(dir_out_b), .cmp_out_a_pin(oa), .cmp_out_a_oe(),
        .cmp_out_a_override(oa_ov), .cmp_out_b_pin(ob), .cmp_out_b_oe(ob_oe),
        .cmp_out_b_override(ob_ov), .overflow_flag(ovf));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] d);
        apb_req <= '{paddr: {idx, 2'b00}, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        xfer(idx, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] msk);
        exp_q.push_back({!(idx inside {IDX_CTRL_A, IDX_CTRL_B, IDX_COUNT, IDX_CMP_A,
            IDX_STATUS, IDX_CMP_B}), msk, exp});
        xfer(idx, 1'b0, 32'h0);
    endtask

    task automatic duty(input int n, input int exp);
        int hi;
        hi = 0;
        repeat (n) begin
            @(posedge pclk);
            hi += (ob === 1'b1);
        end
        chk(32'(hi), 32'(exp));
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task automatic finish_test();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        if (apb_req.psel && apb_req.penable && pready === 1'b1 && !apb_req.pwrite) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                note = exp_q.pop_front();
                chk(prdata & note[63:32], note[31:0]);
                chk(32'(pslverr), 32'(note[64]));
            end
        end
    end

    initial begin
        #(60000 * 25);
        err_total++;
        finish_test();
    end

    initial begin
        apb_req = '0;
        ext_count_pin = 1'b0;
        dir_out_a = 1'b0;
        dir_out_b = 1'b0;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(IDX_CTRL_A, 32'h0, '1);
        rd(IDX_CTRL_B, 32'h0, '1);
        rd(IDX_COUNT, 32'h0, '1);
        rd(8'h3f, 32'h0, '1);
        done("reset");
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            wr(IDX_CTRL_A, r);
            rd(IDX_CTRL_A, {24'h0, r[7:0] & 8'hf3}, '1);
            wr(IDX_CTRL_B, r & 32'hfffffff8);
            rd(IDX_CTRL_B, {24'h0, r[7:0] & 8'h08}, '1);
            wr(IDX_COUNT, r >> 8);
            rd(IDX_COUNT, {24'h0, r[15:8]}, '1);
        end
        done("registers");
        wr(IDX_CTRL_A, 32'h0);
        // The prescaler runs free, so only whole periods give an exact tick count.
        for (int c = 0; c < 6; c++) begin
            wr(IDX_COUNT, 32'h0);
            wr(IDX_CTRL_B, 32'(c));
            repeat (divs[c] * 3 - 3) @(posedge pclk);
            wr(IDX_CTRL_B, 32'h0);
            rd(IDX_COUNT, (c == 0) ? 32'h0 : 32'h3, '1);
        end
        for (int c = 6; c < 8; c++) begin
            wr(IDX_COUNT, 32'h0);
            wr(IDX_CTRL_B, 32'(c));
            repeat (3) begin
                ext_count_pin <= 1'b1;
                repeat (8) @(posedge pclk);
                ext_count_pin <= 1'b0;
                repeat (8) @(posedge pclk);
            end
            // A fourth rise with no fall after it tells the two edge modes apart.
            ext_count_pin <= 1'b1;
            repeat (8) @(posedge pclk);
            wr(IDX_CTRL_B, 32'h0);
            ext_count_pin <= 1'b0;
            rd(IDX_COUNT, (c == 6) ? 32'h3 : 32'h4, '1);
        end
        done("clock select");
        wr(IDX_STATUS, 32'h7);
        wr(IDX_COUNT, 32'h20);
        dir_out_b <= 1'b1;
        dir_out_a <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(IDX_CTRL_A, (i == 0) ? 32'h30 : (i == 1) ? 32'h20 : 32'h10);
            wr(IDX_CTRL_B, 32'h40);
            chk(32'(ob), 32'(!i[0]));
        end
        chk(32'({ob_ov, ob_oe, ovf}), 32'h6);
        wr(IDX_CTRL_A, 32'hc2);
        wr(IDX_CTRL_B, 32'h80);
        chk(32'({oa, ob_ov}), 32'h2);
        rd(IDX_COUNT, 32'h20, '1);
        wr(IDX_CTRL_A, 32'h33);
        wr(IDX_CTRL_B, 32'h40);
        chk(32'(ob), 32'h0);
        done("force");
        wr(IDX_CTRL_A, 32'h10);
        wr(IDX_CMP_B, 32'h5);
        wr(IDX_COUNT, 32'h5);
        wr(IDX_CTRL_B, 32'h1);
        repeat (10) @(posedge pclk);
        chk(32'(ob), 32'h0);
        repeat (256) @(posedge pclk);
        chk(32'(ob), 32'h1);
        done("count write");
        wr(IDX_CMP_A, 32'h3f);
        foreach (rows[i]) begin
            wr(IDX_CTRL_A, 32'(rows[i][39:32]));
            wr(IDX_CMP_B, 32'(rows[i][23:16]));
            wr(IDX_CTRL_B, 32'(rows[i][31:24]));
            repeat (1100) @(posedge pclk);
            duty(rows[i][33] ? 512 : 1020, int'(rows[i][15:0]));
            wr(IDX_STATUS, 32'h1);
            repeat (600) @(posedge pclk);
            chk(32'(ovf), 32'h1);
            done("pwm row");
        end
        finish_test();
    end
endmodule
